// ### inc/tcc_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the timer
// Assumes: Word-addressed Avalon-MM slave, one byte register per word
// Notes: Offsets are word indices; byte address is four times the index
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// Register word indices
`define TCC_OFF_CTL2 4'h0
`define TCC_OFF_CTL1 4'h1
`define TCC_OFF_STAT 4'h2
`define TCC_OFF_CNTH 4'h3
`define TCC_OFF_CNTL 4'h4
`define TCC_OFF_CAPH 4'h5
`define TCC_OFF_CMPH 4'h9

// control_reg_one bits
`define TCC_OLVL1 0
`define TCC_OLVL2 1
`define TCC_IEDG1 2
`define TCC_FOLV1 3
`define TCC_FOLV2 4
`define TCC_TOIE 5
`define TCC_COMPARE_IRQ_ENABLE 6
`define TCC_CAPTURE_IRQ_ENABLE 7
`define TCC_CTL1_STORE 8'hE7

// control_reg_two bits
`define TCC_OPM 2
`define TCC_PWM 3
`define TCC_OC1E 4
`define TCC_OC2E 5
`define TCC_IEDG2 6
`define TCC_EXEDG 7

// timer_status_reg bits; channel i flag sits 3*i lower
`define TCC_ICF1 7
`define TCC_OCF1 6
`define TCC_TOF 5

// Values
`define TCC_CNT_RELOAD 16'hFFFC
`define TCC_OPM_CAP 16'hFFFD
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CMP_RST 16'h8000
`define TCC_PIN_LANES 3

`endif

// ### inc/tcc_pkg.sv
// Purpose: Types shared by the timer modules
// Assumes: tcc_defines.svh on the include path
// Notes: None
`include "tcc_defines.svh"

package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_DIV2 = 2'b00,
    TCC_DIV4 = 2'b01,
    TCC_DIV8 = 2'b10,
    TCC_EXT = 2'b11
  } tcc_clk_sel_type;

  typedef struct packed {
    logic [`TCC_PIN_LANES-1:0] s1;
    logic [`TCC_PIN_LANES-1:0] s2;
    logic [`TCC_PIN_LANES-1:0] s3;
    logic [`TCC_PIN_LANES-1:0] lvl;
    logic [`TCC_PIN_LANES-1:0] rise;
    logic [`TCC_PIN_LANES-1:0] fall;
  } tcc_sync_state_type;

  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] flag;
    logic [7:0] arm;
    logic [15:0] cnt;
    logic [1:0][15:0] cap;
    logic [1:0][15:0] cmp;
    logic [1:0] cap_blk;
    logic [1:0] cmp_inh;
    logic [2:0] div;
    logic [1:0] pin;
    logic [1:0] oe;
    logic irq;
    logic wreq;
    logic [7:0] rdata;
  } tcc_core_state_type;

endpackage

// ### inc/tcc_pin_if.sv
// Purpose: Carries synchronised pin levels and edges to the timer core
// Assumes: Lane 0 capture one, lane 1 capture two, lane 2 external clock
// Notes: All signals are registered one-cycle pulses or levels
`timescale 1ns/1ps
`include "tcc_defines.svh"

interface tcc_pin_if;
  logic [`TCC_PIN_LANES-1:0] level;
  logic [`TCC_PIN_LANES-1:0] rise;
  logic [`TCC_PIN_LANES-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ### hdl/tcc_pin_sync.sv
// Purpose: Three-flop synchroniser and edge detector for the timer pins
// Assumes: Pins are asynchronous to clock
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ps

module tcc_pin_sync
  import tcc_pkg::*;
#(
  parameter int LANES = `TCC_PIN_LANES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Raw pins
  input wire logic [LANES-1:0] raw,
  // Synchronised result
  tcc_pin_if.src pins
);

  if (LANES != `TCC_PIN_LANES) begin : g_check
    $error("tcc_pin_sync: LANES must match the state struct");
  end

  tcc_sync_state_type s_r;
  tcc_sync_state_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second, so metastability cannot reach edges
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = raw;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.lvl = (s_r.s2 == s_r.s3) ? s_r.s2 : s_r.lvl; // see RULE28
    s_nxt.rise = ~s_r.lvl & s_nxt.lvl;
    s_nxt.fall = s_r.lvl & ~s_nxt.lvl;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.level = s_r.lvl;
  assign pins.rise = s_r.rise;
  assign pins.fall = s_r.fall;

endmodule

// ### hdl/tcc_timer.sv
// Purpose: 16-bit timer with two captures, two compares and one-pulse mode
// Assumes: Avalon-MM word addressing, byte-wide registers in bits 7:0
// Notes: One wait state per access; pins pass three synchroniser flops
//
// Contract
// RULE1: Each capture channel copies the counter into its register on an edge.
// RULE2: Edge polarity of each capture comes from its edge-select bit.
// RULE3: Capture sets its flag; irq when capture enable set and cpu mask clear.
// RULE4: Capture flag clears after status read then capture low byte access.
// RULE5: Reading capture high byte blocks capture and flag until low byte read.
// RULE6: Capture register always holds the latest event's counter value.
// RULE7: Capture pins always feed capture logic, whatever their direction.
// RULE8: In one-pulse or PWM mode only capture two captures.
// RULE9: Compare matches counter each tick; sets flag, irq when enabled.
// RULE10: On match with output enable set, pin takes output level.
// RULE11: Compare registers are software only; reset value 8000h.
// RULE12: Compare pin latches are low during reset.
// RULE13: Compare flag clears after status read then compare low access.
// RULE14: High-byte write inhibits compare until low write, which clears flag.
// RULE15: Without output enable, match sets flag and irq but not pin.
// RULE16: Flag and pin take effect while counter equals compare value.
// RULE17: Force bit copies level to pin, no flag; ignored in ONE_PULSE_SELECT or PWM.
// RULE18: One-pulse select in control two; capture one triggers, compare one ends.
// RULE19: ONE_PULSE_SELECT trigger reloads FFFCh, pin one to level two, flag, capture FFFDh.
// RULE20: ONE_PULSE_SELECT match on compare one drives pin one to level one.
// RULE21: In ONE_PULSE_SELECT compare one flag never sets; compare two sets flag only.
// RULE22: PWM wins when PWM and one-pulse bits are both set.
// RULE23: Pulse lasts compare one value plus 5 timer counts; the code ends it after value plus 4 (FFFCh up to the compare value).
// RULE24: Counter resets to FFFCh; counter low write reloads FFFCh.
// RULE25: Counter ticks at clock over 2, 4, 8 or on external clock.
// RULE26: Rollover FFFFh to 0000h sets the overflow flag.
// RULE27: All timer events share one irq, each gated by its enable.
// RULE28: Capture pins are synchronised and edge detected before use.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

module tcc_timer
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timer pins
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  input wire logic ext_clock_pin,
  output logic [1:0] compare_output_pin,
  output logic [1:0] compare_output_oe,
  // Cpu interrupt
  input wire logic cpu_irq_mask,
  output logic timer_irq
);

  localparam tcc_core_state_type CORE_RST = '{
    cnt: `TCC_CNT_RELOAD,
    cmp: {`TCC_CMP_RST, `TCC_CMP_RST},
    wreq: 1'b1,
    default: '0
  };

  tcc_core_state_type s_r;
  tcc_core_state_type s_nxt;
  tcc_pin_if pins();

  logic pwm;
  logic one_pulse_select;
  logic tick;
  logic ext_evt;
  logic acc;
  logic rd;
  logic wr;
  logic [7:0] wd;
  logic [2:0] pmask;
  logic [15:0] inc;
  logic [1:0] iedg;
  logic [1:0] oce;
  logic [1:0] olvl;
  logic [1:0] cev;
  logic [1:0] match;
  tcc_clk_sel_type csel;

  ////////////////////////////////////////////////////////////////////////////
  // Pins; capture inputs are never gated by pin direction
  tcc_pin_sync #(
    .LANES(`TCC_PIN_LANES)
  ) tcc_pin_sync_inst (
    .clock(clock),
    .rst_n(rst_n),
    .raw({ext_clock_pin, capture_pin_two, capture_pin_one}), // see RULE7
    .pins(pins.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of modes, clock and events
  assign pwm = s_r.ctl2[`TCC_PWM];
  assign one_pulse_select = s_r.ctl2[`TCC_OPM] & ~pwm; // see RULE22 RULE18
  assign csel = tcc_clk_sel_type'(s_r.ctl2[1:0]);
  assign pmask = (csel == TCC_DIV2) ? 3'h1 : (csel == TCC_DIV4) ? 3'h3 : 3'h7;
  assign ext_evt = s_r.ctl2[`TCC_EXEDG] ? pins.rise[2] : pins.fall[2];
  // Tick every 2, 4 or 8 clocks, or per external edge; see RULE25 RULE23
  assign tick = (csel == TCC_EXT) ? ext_evt : ((s_r.div & pmask) == pmask);
  assign inc = s_r.cnt + 16'h0001;
  assign iedg = {s_r.ctl2[`TCC_IEDG2], s_r.ctl1[`TCC_IEDG1]};
  assign oce = {s_r.ctl2[`TCC_OC2E], s_r.ctl2[`TCC_OC1E]};
  assign olvl = {s_r.ctl1[`TCC_OLVL2], s_r.ctl1[`TCC_OLVL1]};

  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign cev[i] = iedg[i] ? pins.rise[i] : pins.fall[i]; // see RULE2
    // Compare against the value being loaded, so flag and pin change with
    // the counter and stand during the equal state; see RULE9 RULE16
    assign match[i] = tick & ~s_r.cmp_inh[i] & (inc == s_r.cmp[i]);
  end

  assign acc = (avs_read | avs_write) & s_r.wreq;
  assign rd = acc & avs_read;
  assign wr = acc & avs_write;
  assign wd = avs_writedata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] fset;
    logic [7:0] fclr;
    fset = 8'h00;
    fclr = 8'h00;
    s_nxt = s_r;
    s_nxt.div = s_r.div + 3'h1;
    // One wait state: the access acts on the first edge of the request
    s_nxt.wreq = (avs_read | avs_write) ? ~s_r.wreq : 1'b1;
    s_nxt.oe = {oce[1] & ~(one_pulse_select | pwm), oce[0]};
    if (tick) begin
      s_nxt.cnt = inc;
      if (s_r.cnt == `TCC_CNT_MAX) begin
        fset[`TCC_TOF] = 1'b1; // see RULE26
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (match[i] && !pwm && !(one_pulse_select && i == 0)) begin
        fset[`TCC_OCF1 - 3 * i] = 1'b1; // see RULE9 RULE15 RULE21
      end
      if (match[i] && !pwm && !one_pulse_select && oce[i]) begin
        s_nxt.pin[i] = olvl[i]; // see RULE10 RULE15
      end
      if (cev[i] && !s_r.cap_blk[i] && !(i == 0 && (one_pulse_select || pwm))) begin
        s_nxt.cap[i] = s_r.cnt; // see RULE1 RULE6 RULE8
        fset[`TCC_ICF1 - 3 * i] = 1'b1; // see RULE3 RULE5
      end
    end
    if (one_pulse_select) begin
      if (match[0]) begin
        s_nxt.pin[0] = olvl[0]; // see RULE20
      end
      if (cev[0]) begin
        s_nxt.cnt = `TCC_CNT_RELOAD; // see RULE19
        s_nxt.pin[0] = olvl[1];
        fset[`TCC_ICF1] = 1'b1;
        s_nxt.cap[0] = `TCC_OPM_CAP;
      end
    end
    if (pwm) begin
      if (match[0]) begin
        s_nxt.pin[0] = olvl[0];
      end
      if (match[1]) begin
        s_nxt.pin[0] = olvl[1];
        s_nxt.cnt = `TCC_CNT_RELOAD;
        fset[`TCC_ICF1] = 1'b1;
      end
    end
    if (acc) begin
      s_nxt.rdata = 8'h00;
      case (avs_address)
        `TCC_OFF_CTL2: begin
          s_nxt.rdata = s_r.ctl2;
          if (wr) begin
            s_nxt.ctl2 = wd;
          end
        end
        `TCC_OFF_CTL1: begin
          s_nxt.rdata = s_r.ctl1;
          if (wr) begin
            s_nxt.ctl1 = wd & `TCC_CTL1_STORE;
            for (int i = 0; i < 2; i++) begin
              if (wd[`TCC_FOLV1 + i] && !one_pulse_select && !pwm) begin
                s_nxt.pin[i] = wd[`TCC_OLVL1 + i]; // see RULE17
              end
            end
          end
        end
        `TCC_OFF_STAT: begin
          s_nxt.rdata = s_r.flag;
          if (rd) begin
            s_nxt.arm = s_r.flag; // see RULE4 RULE13
          end
        end
        `TCC_OFF_CNTH: begin
          s_nxt.rdata = s_r.cnt[15:8];
        end
        `TCC_OFF_CNTL: begin
          s_nxt.rdata = s_r.cnt[7:0];
          fclr[`TCC_TOF] = s_r.arm[`TCC_TOF];
          if (wr) begin
            s_nxt.cnt = `TCC_CNT_RELOAD; // see RULE24
          end
        end
        default: begin
        end
      endcase
      for (int i = 0; i < 2; i++) begin
        if (avs_address == 4'(`TCC_OFF_CAPH + 2 * i)) begin
          s_nxt.rdata = s_r.cap[i][15:8];
          if (rd) begin
            s_nxt.cap_blk[i] = 1'b1; // see RULE5
          end
        end
        if (avs_address == 4'(`TCC_OFF_CAPH + 2 * i + 1)) begin
          s_nxt.rdata = s_r.cap[i][7:0];
          fclr[`TCC_ICF1 - 3 * i] = s_r.arm[`TCC_ICF1 - 3 * i]; // see RULE4
          if (rd) begin
            s_nxt.cap_blk[i] = 1'b0;
          end
        end
        if (avs_address == 4'(`TCC_OFF_CMPH + 2 * i)) begin
          s_nxt.rdata = s_r.cmp[i][15:8];
          if (wr) begin
            s_nxt.cmp[i][15:8] = wd; // see RULE11
            s_nxt.cmp_inh[i] = 1'b1; // see RULE14
          end
        end
        if (avs_address == 4'(`TCC_OFF_CMPH + 2 * i + 1)) begin
          s_nxt.rdata = s_r.cmp[i][7:0];
          fclr[`TCC_OCF1 - 3 * i] = s_r.arm[`TCC_OCF1 - 3 * i]; // see RULE13
          if (wr) begin
            s_nxt.cmp[i][7:0] = wd;
            s_nxt.cmp_inh[i] = 1'b0; // see RULE14
            fclr[`TCC_OCF1 - 3 * i] = 1'b1;
          end
        end
      end
    end
    // A hardware set in the clearing cycle wins over the clear
    s_nxt.flag = (s_r.flag & ~fclr) | fset;
    s_nxt.arm = s_nxt.arm & ~fclr;
    // Pending flags raise the shared request once both gates allow; see RULE27
    s_nxt.irq = ~cpu_irq_mask & (
      (s_r.ctl1[`TCC_CAPTURE_IRQ_ENABLE] & (s_r.flag[`TCC_ICF1] | s_r.flag[`TCC_ICF1 - 3])) |
      (s_r.ctl1[`TCC_COMPARE_IRQ_ENABLE] & (s_r.flag[`TCC_OCF1] | s_r.flag[`TCC_OCF1 - 3])) |
      (s_r.ctl1[`TCC_TOIE] & s_r.flag[`TCC_TOF])); // see RULE3
  end

  // Pin latches and compare values take constants in reset; see RULE12 RULE11
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = {24'h000000, s_r.rdata};
  assign avs_waitrequest = s_r.wreq;
  assign compare_output_pin = s_r.pin;
  assign compare_output_oe = s_r.oe;
  assign timer_irq = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_cap_copy: assert property (cev[1] && !s_r.cap_blk[1] |=> s_r.cap[1] == $past(s_r.cnt)) // RULE1
    else $error("capture two did not take the counter");
  a_irq_gate: assert property (s_r.flag[`TCC_ICF1] && s_r.ctl1[`TCC_CAPTURE_IRQ_ENABLE] && !cpu_irq_mask
    |=> timer_irq) // RULE3
    else $error("capture irq missing");
  a_cap_clear: assert property ($fell(s_r.flag[`TCC_ICF1])
    |-> $past(acc && avs_address == `TCC_OFF_CAPH + 4'h1 && s_r.arm[`TCC_ICF1])) // RULE4
    else $error("capture flag cleared without the two steps");
  a_cap_block: assert property (s_r.cap_blk[1] |=> $stable(s_r.cap[1])) // RULE5
    else $error("blocked capture changed");
  a_opm_cap_one: assert property ((one_pulse_select || pwm) && !cev[0] |=> $stable(s_r.cap[0])) // RULE8
    else $error("capture one active in pulse mode");
  a_cmp_pin: assert property (match[0] && oce[0] && !one_pulse_select && !pwm
    |=> compare_output_pin[0] == $past(olvl[0])) // RULE10
    else $error("compare pin missed its level");
  a_cmp_sw_only: assert property (!(wr && avs_address >= `TCC_OFF_CMPH)
    |=> $stable(s_r.cmp)) // RULE11
    else $error("compare register changed without a write");
  a_opm_trigger: assert property (one_pulse_select && cev[0] && !acc
    |=> s_r.cnt == `TCC_CNT_RELOAD && s_r.cap[0] == `TCC_OPM_CAP
    && s_r.flag[`TCC_ICF1]) // RULE19
    else $error("one-pulse trigger incomplete");
  a_opm_no_ocf: assert property (one_pulse_select |=> !$rose(s_r.flag[`TCC_OCF1])) // RULE21
    else $error("compare one flag set in one-pulse mode");
  a_overflow: assert property (tick && s_r.cnt == `TCC_CNT_MAX && !acc
    |=> s_r.cnt == 16'h0000 && s_r.flag[`TCC_TOF]) // RULE26
    else $error("overflow flag not set on rollover");
  a_bus_wait: assert property (acc |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait state");

  c_capture: cover property (cev[0] && !s_r.cap_blk[0] && !one_pulse_select && !pwm);
  c_match: cover property (match[1] && oce[1]);
  c_opm_pulse: cover property (one_pulse_select && cev[0] ##[1:1000] one_pulse_select && match[0]);
  c_irq: cover property ($rose(timer_irq));

endmodule

// ### verification/tcc_pin_model.sv
// Purpose: Far-side pin source for the timer capture inputs
// Assumes: Bench asks for pin levels, model launches them after a clock edge
// Notes: External clock pin stands still since no scenario selects it
`timescale 1ns/1ps

module tcc_pin_model (
  // Clock
  clock,
  // Requested levels
  want_one,
  want_two,
  // Pins toward the timer
  capture_pin_one,
  capture_pin_two,
  ext_clock_pin
);
  input wire logic clock;
  input wire logic want_one;
  input wire logic want_two;
  output logic capture_pin_one;
  output logic capture_pin_two;
  output logic ext_clock_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Levels change only after an edge, as from a source clocked elsewhere
  always_ff @(posedge clock) begin
    capture_pin_one <= want_one;
    capture_pin_two <= want_two;
  end
  assign ext_clock_pin = 1'b0;
endmodule

// ### verification/tcc_timer_capture_compare_one_pulse_test.sv
// Purpose: Self-checking bench for the capture and compare timer
// Assumes: One wait state per bus access, timer clock is clock over two
// Notes: Pulse length window allows for pin synchroniser delay
`timescale 1ns/1ps

module timer_capture_compare_one_pulse_test;
  import tcc_pkg::*;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic cap_one, cap_two, ext_pin, want_one, want_two, cpu_irq_mask, timer_irq;
  logic [1:0] cmp_pin, cmp_oe;
  int fail_count, comparisons;

  tcc_timer tcc_timer_inst (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_pin_one(cap_one), .capture_pin_two(cap_two), .ext_clock_pin(ext_pin),
    .compare_output_pin(cmp_pin), .compare_output_oe(cmp_oe),
    .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));
  tcc_pin_model tcc_pin_model_inst (.clock(clock), .want_one(want_one),
    .want_two(want_two), .capture_pin_one(cap_one), .capture_pin_two(cap_two),
    .ext_clock_pin(ext_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let an edge pass so a following call never reassigns in this step
    @(posedge clock);
    if (n >= 50) chk("bus answer", 16'h0001, 16'h0000);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 4'h1, v[7:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [15:0] v;
    logic [7:0] st;
    chk("pins in reset", 16'h0000, {14'h0000, cmp_pin});
    rd16(4'h9, v);
    chk("compare one reset", 16'h8000, v);
    rd16(4'hB, v);
    chk("compare two reset", 16'h8000, v);
    rd(4'h2, st);
    // Counter leaves reset at FFFCh, so it has rolled over by now
    chk("status reset", 16'h0000, {8'h00, st & 8'hD8});
    chk("overflow after rollover", 16'h0001, {15'h0000, st[5]});
  endtask

  task automatic t_compare;
    logic [7:0] st;
    logic [15:0] v;
    int n;
    wr(4'h0, 8'h10);
    wr(4'h1, 8'h01);
    wr(4'h4, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h20);
    n = 0;
    while (cmp_pin[0] !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("compare pin one", 16'h0001, {15'h0000, cmp_pin[0]});
    rd(4'h2, st);
    chk("compare and overflow flags", 16'h0060, {8'h00, st & 8'h60});
    chk("irq gated off", 16'h0000, {15'h0000, timer_irq});
    rd(4'hA, st);
    rd(4'h2, st);
    chk("compare flag cleared", 16'h0000, {8'h00, st & 8'h40});
    rd16(4'h9, v);
    chk("compare one value", 16'h0020, v);
  endtask

  task automatic t_force;
    logic [7:0] st;
    wr(4'h0, 8'h30);
    wr(4'h1, 8'h12);
    @(posedge clock);
    chk("forced pin two", 16'h0003, {14'h0000, cmp_oe[1], cmp_pin[1]});
    wr(4'h1, 8'h08);
    @(posedge clock);
    chk("forced pin one low", 16'h0000, {15'h0000, cmp_pin[0]});
    rd(4'h2, st);
    chk("no flag on force", 16'h0000, {8'h00, st & 8'h48});
  endtask

  task automatic t_capture;
    logic [7:0] st;
    wr(4'h1, 8'h84);
    want_one <= 1'b1;
    repeat (10) @(posedge clock);
    rd(4'h2, st);
    chk("capture flag one", 16'h0001, {15'h0000, st[7]});
    chk("irq raised", 16'h0001, {15'h0000, timer_irq});
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge clock);
    chk("irq masked", 16'h0000, {15'h0000, timer_irq});
    cpu_irq_mask <= 1'b0;
    rd(4'h5, st);
    rd(4'h6, st);
    rd(4'h2, st);
    chk("capture flag cleared", 16'h0000, {15'h0000, st[7]});
    rd(4'h5, st);
    want_one <= 1'b0;
    repeat (4) @(posedge clock);
    want_one <= 1'b1;
    repeat (10) @(posedge clock);
    rd(4'h2, st);
    chk("capture blocked", 16'h0000, {15'h0000, st[7]});
    rd(4'h6, st);
    want_two <= 1'b0;
    repeat (10) @(posedge clock);
    rd(4'h2, st);
    chk("falling capture two", 16'h0001, {15'h0000, st[4]});
  endtask

  task automatic t_one_pulse;
    logic [7:0] st;
    logic [15:0] v;
    int n;
    want_one <= 1'b0;
    wr(4'h1, 8'h06);
    wr(4'h0, 8'h14);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h10);
    repeat (10) @(posedge clock);
    want_one <= 1'b1;
    n = 0;
    while (cmp_pin[0] !== 1'b1 && n < 30) begin
      @(posedge clock);
      n++;
    end
    chk("pulse starts", 16'h0001, {15'h0000, cmp_pin[0]});
    while (cmp_pin[0] === 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("pulse ends", 16'h0000, {15'h0000, cmp_pin[0]});
    // Value 10h plus 4 counts at two clocks, plus up to ten of pin delay
    chk("pulse length", 16'h0001, {15'h0000, n >= 40 && n <= 50});
    rd(4'h2, st);
    chk("opm flags", 16'h0080, {8'h00, st & 8'hC0});
    rd16(4'h5, v);
    chk("opm capture value", 16'hFFFD, v);
  endtask

  task automatic t_pwm;
    logic [7:0] st;
    int n;
    wr(4'h4, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'hB, 8'h00);
    wr(4'hC, 8'h30);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h10);
    wr(4'h0, 8'h1C);
    n = 0;
    while (cmp_pin[0] !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("pwm period pin", 16'h0001, {15'h0000, cmp_pin[0]});
    rd(4'h2, st);
    chk("pwm flags", 16'h0080, {8'h00, st & 8'hC8});
  endtask

  task automatic t_unmapped;
    logic [7:0] st;
    rd(4'hE, st);
    chk("unmapped read", 16'h0000, {8'h00, st});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("Checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #200us;
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    want_one = 1'b0;
    want_two = 1'b1;
    cpu_irq_mask = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_compare();
    t_force();
    t_capture();
    t_one_pulse();
    t_pwm();
    t_unmapped();
    conclude();
  end
endmodule
